/* File: async_serial_defs.vh */
`ifndef ASYNC_SERIAL_DEFS_VH
`define ASYNC_SERIAL_DEFS_VH
// register offsets on the host port
`define OFS_HOLD 3'h0
`define OFS_MASK 3'h1
`define OFS_IDENT 3'h2
`define OFS_FORMAT 3'h3
`define OFS_MCTRL 3'h4
`define OFS_LSTATE 3'h5
`define OFS_MSTATE 3'h6
`define OFS_SCRATCH 3'h7
// line format field positions
`define FMT_STOP 2
`define FMT_PAR 3
`define FMT_EVEN 4
`define FMT_STICK 5
`define FMT_BREAK 6
`define FMT_DIV 7
// interrupt mask field positions
`define MASK_RXD 0
`define MASK_HOLD 1
`define MASK_LINE 2
`define MASK_MODEM 3
// identification codes, bits 2..1
`define ID_LINE 2'b11
`define ID_RXD 2'b10
`define ID_HOLD 2'b01
`define ID_MODEM 2'b00
// reset values
`define RST_MASK 4'h0
`define RST_FORMAT 8'h00
`define RST_MCTRL 5'h00
`define RST_DIVISOR 16'h0001
`define RST_IDENT 8'h01
`define RST_SCRATCH 8'h00
// timing in 16x ticks, last tick index of each span
`define TICK_START_MID 4'h7
`define TICK_BIT_LAST 4'hf
`define TICK_STOP_ONE 5'h0f
`define TICK_STOP_HALF 5'h17
`define TICK_STOP_TWO 5'h1f
`endif

/* File: baud_divider.v */
`timescale 1ns/1ns
`include "async_serial_defs.vh"
module baud_divider #(
	parameter WIDTH = 16
) (
	// clock and reset
	input wire ref_clk_i,
	input wire sys_rst_i,
	// divisor from the two latch bytes
	input wire [WIDTH-1:0] divisor_i,
	// one-cycle pulse at 16x bit rate
	output reg tick_o
);

reg [WIDTH-1:0] count;

////////////////////////////////////////////////////////////////
// divide by divisor; zero stops the timebase
always @(posedge ref_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		count <= {WIDTH{1'b0}};
		tick_o <= 1'b0;
	end else if (divisor_i == {WIDTH{1'b0}}) begin
		count <= {WIDTH{1'b0}};
		tick_o <= 1'b0;
	end else if (count >= divisor_i - 1'b1) begin
		count <= {WIDTH{1'b0}};
		tick_o <= 1'b1;
	end else begin
		count <= count + 1'b1;
		tick_o <= 1'b0;
	end
end

endmodule // baud_divider

/* File: serial_receiver.v */
`timescale 1ns/1ns
`include "async_serial_defs.vh"
module serial_receiver (
	// clock and reset
	input wire ref_clk_i,
	input wire sys_rst_i,
	// timebase and synchronised line
	input wire tick_i,
	input wire rxd_i,
	input wire [7:0] format_i,
	// completed character
	output reg done_o,
	output reg [7:0] data_o,
	output reg parity_err_o,
	output reg frame_err_o,
	output reg break_o
);

localparam S_IDLE = 3'd0;
localparam S_START = 3'd1;
localparam S_DATA = 3'd2;
localparam S_PAR = 3'd3;
localparam S_STOP = 3'd4;

// parity over the active data bits
function par_of;
	input [7:0] d;
	input [7:0] f;
	reg [7:0] m;
	begin
		m = d & (8'hff >> (2'd3 - f[1:0]));
		if (f[`FMT_STICK])
			par_of = ~f[`FMT_EVEN];
		else
			par_of = f[`FMT_EVEN] ? ^m : ~^m;
	end
endfunction

reg [2:0] state;
reg [3:0] cnt;
reg [2:0] bitn;
reg [7:0] shift;
reg pbit;
reg prev;
wire [2:0] last_bit = {1'b1, format_i[1:0]};

////////////////////////////////////////////////////////////////
// start validation and mid-bit sampling
always @(posedge ref_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		state <= S_IDLE;
		cnt <= 4'h0;
		bitn <= 3'd0;
		shift <= 8'h00;
		pbit <= 1'b0;
		prev <= 1'b1;
		done_o <= 1'b0;
		data_o <= 8'h00;
		parity_err_o <= 1'b0;
		frame_err_o <= 1'b0;
		break_o <= 1'b0;
	end else begin
		prev <= rxd_i;
		done_o <= 1'b0;
		case (state)
		S_IDLE: begin
			cnt <= 4'h0;
			if (prev && !rxd_i)
				state <= S_START;
		end
		S_START: if (tick_i) begin
			if (cnt == `TICK_START_MID) begin
				cnt <= 4'h0;
				bitn <= 3'd0;
				shift <= 8'h00;
				pbit <= 1'b0;
				// a spike that is gone by mid-bit is dropped
				state <= rxd_i ? S_IDLE : S_DATA;
			end else
				cnt <= cnt + 1'b1;
		end
		S_DATA: if (tick_i) begin
			cnt <= cnt + 1'b1;
			if (cnt == `TICK_BIT_LAST) begin
				shift[bitn] <= rxd_i;
				bitn <= bitn + 1'b1;
				if (bitn == last_bit)
					state <= format_i[`FMT_PAR] ? S_PAR : S_STOP;
			end
		end
		S_PAR: if (tick_i) begin
			cnt <= cnt + 1'b1;
			if (cnt == `TICK_BIT_LAST) begin
				pbit <= rxd_i;
				state <= S_STOP;
			end
		end
		S_STOP: if (tick_i) begin
			cnt <= cnt + 1'b1;
			if (cnt == `TICK_BIT_LAST) begin
				done_o <= 1'b1;
				data_o <= shift;
				parity_err_o <= format_i[`FMT_PAR] &&
					(pbit != par_of(shift, format_i));
				frame_err_o <= !rxd_i;
				break_o <= !rxd_i && shift == 8'h00 && !pbit;
				state <= S_IDLE;
			end
		end
		default: state <= S_IDLE;
		endcase
	end
end

endmodule // serial_receiver

/* File: async_serial_channel.v */
`timescale 1ns/1ns
`include "async_serial_defs.vh"
module async_serial_channel #(
	parameter DIV_WIDTH = 16
) (
	// clock and reset
	input wire ref_clk_i,
	input wire sys_rst_i,
	// host register port
	input wire [2:0] addr_i,
	input wire [7:0] wr_data_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rd_data_o,
	// serial line
	input wire rxd_i,
	output reg txd_o,
	output wire baud_out_o,
	// modem lines, active low
	input wire cts_n_i,
	input wire dsr_n_i,
	input wire ri_n_i,
	input wire cd_n_i,
	output reg dtr_n_o,
	output reg rts_n_o,
	output reg user_output_two_n_o,
	// interrupt pin
	output reg int_o,
	output reg int_oe_o
);

localparam T_IDLE = 3'd0;
localparam T_START = 3'd1;
localparam T_DATA = 3'd2;
localparam T_PAR = 3'd3;
localparam T_STOP = 3'd4;

// parity over the active data bits
function par_of;
	input [7:0] d;
	input [7:0] f;
	reg [7:0] m;
	begin
		m = d & (8'hff >> (2'd3 - f[1:0]));
		if (f[`FMT_STICK])
			par_of = ~f[`FMT_EVEN];
		else
			par_of = f[`FMT_EVEN] ? ^m : ~^m;
	end
endfunction

////////////////////////////////////////////////////////////////
// pin synchronisers: cts, dsr, ri, cd, rxd
reg [4:0] pin_s1;
reg [4:0] pin_s2;
reg [3:0] modem_prev;

always @(posedge ref_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		pin_s1 <= 5'h1f;
		pin_s2 <= 5'h1f;
	end else begin
		pin_s1 <= {rxd_i, cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
		pin_s2 <= pin_s1;
	end
end

////////////////////////////////////////////////////////////////
// register state
reg [3:0] mask;
reg [7:0] format;
reg [4:0] mctrl;
reg [7:0] scratch;
reg [DIV_WIDTH-1:0] divisor;
reg [7:0] hold_data;
reg hold_empty;
reg hold_irq;
reg [7:0] rx_data;
reg data_ready;
reg overrun;
reg perr;
reg ferr;
reg brk;
reg [3:0] mdelta;

// transmitter state
reg [2:0] tstate;
reg [4:0] tcnt;
reg [2:0] tbit;
reg [7:0] tshift;
reg tpar;

// receiver and timebase wires
wire tick;
wire rx_done;
wire [7:0] rx_char;
wire rx_perr;
wire rx_ferr;
wire rx_brk;

////////////////////////////////////////////////////////////////
// address decode; divisor bytes bank over offsets 0 and 1
wire div_sel = format[`FMT_DIV];
wire at_hold = addr_i == `OFS_HOLD;
wire at_mask = addr_i == `OFS_MASK;
wire wr_hold = wr_i && at_hold && !div_sel;
wire wr_mask = wr_i && at_mask && !div_sel;
wire wr_dlo = wr_i && at_hold && div_sel;
wire wr_dhi = wr_i && at_mask && div_sel;
wire rd_hold = rd_i && at_hold && !div_sel;
wire rd_ident = rd_i && addr_i == `OFS_IDENT;
wire rd_lstate = rd_i && addr_i == `OFS_LSTATE;
wire rd_mstate = rd_i && addr_i == `OFS_MSTATE;

// transmitter takes the held character when idle
wire tx_idle = tstate == T_IDLE;
wire tx_load = tx_idle && !hold_empty;
// a write while both stages are full is dropped
wire hold_take = wr_hold && (hold_empty || tx_idle);

////////////////////////////////////////////////////////////////
// interrupt sources after masking
wire line_pend = mask[`MASK_LINE] &&
	(overrun || perr || ferr || brk);
wire rxd_pend = mask[`MASK_RXD] && data_ready;
wire hold_pend = mask[`MASK_HOLD] && hold_irq;
wire modem_pend = mask[`MASK_MODEM] && |mdelta;

// priority encode; a lower source stays hidden meanwhile
reg [7:0] ident;
always @* begin
	ident = `RST_IDENT;
	if (line_pend)
		ident = {5'h00, `ID_LINE, 1'b0};
	else if (rxd_pend)
		ident = {5'h00, `ID_RXD, 1'b0};
	else if (hold_pend)
		ident = {5'h00, `ID_HOLD, 1'b0};
	else if (modem_pend)
		ident = {5'h00, `ID_MODEM, 1'b0};
end

wire temt = hold_empty && tx_idle;
wire [7:0] lstate = {1'b0, temt, hold_empty, brk, ferr, perr,
	overrun, data_ready};
wire [7:0] mstate = {~pin_s2[3:0], mdelta};

////////////////////////////////////////////////////////////////
// read data selection
reg [7:0] rmux;
always @* begin
	case (addr_i)
	`OFS_HOLD: rmux = div_sel ? divisor[7:0] : rx_data;
	`OFS_MASK: rmux = div_sel ? divisor[15:8] : {4'h0, mask};
	`OFS_IDENT: rmux = ident;
	`OFS_FORMAT: rmux = format;
	`OFS_MCTRL: rmux = {3'h0, mctrl};
	`OFS_LSTATE: rmux = lstate;
	`OFS_MSTATE: rmux = mstate;
	default: rmux = scratch;
	endcase
end

////////////////////////////////////////////////////////////////
// host writes to control registers
always @(posedge ref_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		mask <= `RST_MASK;
		format <= `RST_FORMAT;
		mctrl <= `RST_MCTRL;
		scratch <= `RST_SCRATCH;
		divisor <= `RST_DIVISOR;
	end else if (wr_i) begin
		if (wr_mask)
			mask <= wr_data_i[3:0];
		if (wr_dlo)
			divisor[7:0] <= wr_data_i;
		if (wr_dhi)
			divisor[15:8] <= wr_data_i;
		if (addr_i == `OFS_FORMAT)
			format <= wr_data_i;
		if (addr_i == `OFS_MCTRL)
			mctrl <= wr_data_i[4:0];
		if (addr_i == `OFS_SCRATCH)
			scratch <= wr_data_i;
	end
end

////////////////////////////////////////////////////////////////
// holding register and its empty flag
always @(posedge ref_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		hold_data <= 8'h00;
		hold_empty <= 1'b1;
	end else begin
		if (tx_load)
			hold_empty <= 1'b1;
		// write after load so a same-cycle write stays held
		if (hold_take) begin
			hold_data <= wr_data_i;
			hold_empty <= 1'b0;
		end
	end
end

// hold interrupt: set on move to shifter, or on enable while empty
wire hold_set = tx_load ||
	(wr_mask && wr_data_i[`MASK_HOLD] && hold_empty);
wire hold_clr = hold_take ||
	(rd_ident && ident[2:0] == {`ID_HOLD, 1'b0});

always @(posedge ref_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i)
		hold_irq <= 1'b0;
	else if (hold_set)
		hold_irq <= 1'b1;
	else if (hold_clr)
		hold_irq <= 1'b0;
end

////////////////////////////////////////////////////////////////
// transmit shifter, advanced by the 16x tick
wire [4:0] stop_last = !format[`FMT_STOP] ? `TICK_STOP_ONE :
	(format[1:0] == 2'b00) ? `TICK_STOP_HALF : `TICK_STOP_TWO;
wire cell_end = tcnt == {1'b0, `TICK_BIT_LAST};

always @(posedge ref_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		tstate <= T_IDLE;
		tcnt <= 5'h00;
		tbit <= 3'd0;
		tshift <= 8'h00;
		tpar <= 1'b0;
	end else begin
		case (tstate)
		T_IDLE: if (tx_load) begin
			tshift <= hold_data;
			tpar <= par_of(hold_data, format);
			tcnt <= 5'h00;
			tbit <= 3'd0;
			tstate <= T_START;
		end
		T_START: if (tick) begin
			tcnt <= cell_end ? 5'h00 : tcnt + 1'b1;
			if (cell_end)
				tstate <= T_DATA;
		end
		T_DATA: if (tick) begin
			tcnt <= cell_end ? 5'h00 : tcnt + 1'b1;
			if (cell_end) begin
				tshift <= {1'b0, tshift[7:1]};
				tbit <= tbit + 1'b1;
				if (tbit == {1'b1, format[1:0]})
					tstate <= format[`FMT_PAR] ? T_PAR : T_STOP;
			end
		end
		T_PAR: if (tick) begin
			tcnt <= cell_end ? 5'h00 : tcnt + 1'b1;
			if (cell_end)
				tstate <= T_STOP;
		end
		T_STOP: if (tick) begin
			tcnt <= tcnt + 1'b1;
			if (tcnt == stop_last) begin
				tcnt <= 5'h00;
				tstate <= T_IDLE;
			end
		end
		default: tstate <= T_IDLE;
		endcase
	end
end

// line level for the current cell
reg line_bit;
always @* begin
	case (tstate)
	T_START: line_bit = 1'b0;
	T_DATA: line_bit = tshift[0];
	T_PAR: line_bit = tpar;
	default: line_bit = 1'b1;
	endcase
end

////////////////////////////////////////////////////////////////
// receive status; every set wins over a same-cycle read
always @(posedge ref_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		rx_data <= 8'h00;
		data_ready <= 1'b0;
		overrun <= 1'b0;
		perr <= 1'b0;
		ferr <= 1'b0;
		brk <= 1'b0;
	end else begin
		if (rx_done)
			rx_data <= rx_char;
		data_ready <= rx_done || (data_ready && !rd_hold);
		overrun <= (rx_done && data_ready) ||
			(overrun && !rd_lstate);
		perr <= (rx_done && rx_perr) || (perr && !rd_lstate);
		ferr <= (rx_done && rx_ferr) || (ferr && !rd_lstate);
		brk <= (rx_done && rx_brk) || (brk && !rd_lstate);
	end
end

////////////////////////////////////////////////////////////////
// modem change flags; only the second sync stage is compared
always @(posedge ref_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		modem_prev <= 4'hf;
		mdelta <= 4'h0;
	end else begin
		modem_prev <= pin_s2[3:0];
		mdelta <= (pin_s2[3:0] ^ modem_prev) |
			(mdelta & {4{!rd_mstate}});
	end
end

////////////////////////////////////////////////////////////////
// registered pins and read data
always @(posedge ref_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		rd_data_o <= 8'h00;
		txd_o <= 1'b1;
		dtr_n_o <= 1'b1;
		rts_n_o <= 1'b1;
		user_output_two_n_o <= 1'b1;
		int_o <= 1'b0;
		int_oe_o <= 1'b0;
	end else begin
		if (rd_i)
			rd_data_o <= rmux;
		// break overrides whatever cell is on the line
		txd_o <= format[`FMT_BREAK] ? 1'b0 : line_bit;
		dtr_n_o <= ~mctrl[0];
		rts_n_o <= ~mctrl[1];
		user_output_two_n_o <= ~mctrl[3];
		int_o <= !ident[0];
		int_oe_o <= mctrl[3];
	end
end

////////////////////////////////////////////////////////////////
// timebase and receiver
baud_divider #(
	.WIDTH(DIV_WIDTH)
) u_baud (
	.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i),
	.divisor_i(divisor),
	.tick_o(tick)
);

assign baud_out_o = tick;

serial_receiver u_rx (
	.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i),
	.tick_i(tick),
	.rxd_i(pin_s2[4]),
	.format_i(format),
	.done_o(rx_done),
	.data_o(rx_char),
	.parity_err_o(rx_perr),
	.frame_err_o(rx_ferr),
	.break_o(rx_brk)
);

endmodule // async_serial_channel

/* File: async_serial_channel_assertions.sv */
`timescale 1ns/1ns
module serial_chk (
	// clock and reset
	input wire ref_clk_i,
	input wire sys_rst_i,
	// host port
	input wire [2:0] addr_i,
	input wire [7:0] wr_data_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rd_data_o,
	// line and interrupt
	input wire txd_o,
	input wire baud_out_o,
	input wire int_o
);
	reg [7:0] fmt;
	reg [3:0] mask;
	reg [15:0] div;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////
	// shadow of host-written controls, so no hierarchy peeking
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fmt <= 8'h00;
			mask <= 4'h0;
			div <= 16'h0001;
		end else if (wr_i) begin
			if (addr_i == 3'h3)
				fmt <= wr_data_i;
			if (addr_i == 3'h0 && fmt[7])
				div[7:0] <= wr_data_i;
			if (addr_i == 3'h1 && fmt[7])
				div[15:8] <= wr_data_i;
			if (addr_i == 3'h1 && !fmt[7])
				mask <= wr_data_i[3:0];
		end
	end
	mask_upper_zero_a: assert property (
		rd_i && addr_i == 3'h1 && !fmt[7] |=> rd_data_o[7:4] == 4'h0)
		else $error("mask upper bits set");
	ident_upper_zero_a: assert property (
		rd_i && addr_i == 3'h2 |=> rd_data_o[7:3] == 5'h00)
		else $error("ident upper bits set");
	ident_idle_code_a: assert property (
		rd_i && addr_i == 3'h2 |=> !rd_data_o[0] || rd_data_o[2:1] == 2'h0)
		else $error("code shown with nothing pending");
	ident_pin_match_a: assert property (
		rd_i && addr_i == 3'h2 |=> rd_data_o[0] != int_o)
		else $error("ident bit0 disagrees with pin");
	int_masked_off_a: assert property (
		mask == 4'h0 && $past(mask) == 4'h0 |-> !int_o)
		else $error("interrupt with all sources masked");
	break_holds_low_a: assert property (
		fmt[6] && $past(fmt[6]) |-> !txd_o)
		else $error("line not low during break");
	tick_single_a: assert property (
		baud_out_o && div > 16'h0001 |=> !baud_out_o)
		else $error("tick wider than one clock");
	tick_div_one_a: assert property (
		baud_out_o && div == 16'h0001 && $past(div) == 16'h0001
		|=> baud_out_o)
		else $error("divisor one missed a tick");
endmodule // serial_chk

bind async_serial_channel serial_chk chk (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
	.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
	.rd_data_o(rd_data_o), .txd_o(txd_o), .baud_out_o(baud_out_o),
	.int_o(int_o)
);

/* File: remote_station.sv */
`timescale 1ns/1ns
module remote_station (
	// clock
	input wire ref_clk_i,
	// serial lines seen from the far end
	input wire txd_i,
	output reg rxd_o
);
	localparam CELL = 16; // clocks per bit at divisor one
	initial rxd_o = 1'b1;
	////////////////////////////////////////////////////////////
	// one 8-bit frame, stop level chosen to provoke framing faults
	task send(input [7:0] d, input stop);
		integer i;
		begin
			@(negedge ref_clk_i);
			rxd_o = 1'b0;
			repeat (CELL) @(negedge ref_clk_i);
			for (i = 0; i < 8; i = i + 1) begin
				rxd_o = d[i];
				repeat (CELL) @(negedge ref_clk_i);
			end
			rxd_o = stop;
			repeat (CELL) @(negedge ref_clk_i);
			rxd_o = 1'b1; // idle line is mark
			repeat (2 * CELL) @(negedge ref_clk_i);
		end
	endtask
	// short low glitch, then settle long enough for a fresh start
	task spike;
		begin
			rxd_o = 1'b0;
			repeat (4) @(negedge ref_clk_i);
			rxd_o = 1'b1;
			repeat (2 * CELL) @(negedge ref_clk_i);
		end
	endtask
	// sample bits mid-cell, then time start-to-start of next frame
	task grab_frame(input integer nb, output [11:0] bits,
		output integer gap);
		integer i;
		integer t0;
		begin
			@(negedge txd_i);
			t0 = $time;
			bits = 12'h000;
			repeat (CELL / 2) @(posedge ref_clk_i);
			for (i = 0; i <= nb; i = i + 1) begin
				repeat (CELL) @(posedge ref_clk_i);
				bits[i] = txd_i;
			end
			@(negedge txd_i);
			gap = ($time - t0) / 10;
		end
	endtask
endmodule // remote_station

/* File: async_serial_channel_tb.sv */
`timescale 1ns/1ns
module async_serial_channel_tb;
	localparam [55:0] FMTS = 56'h00_05_04_0b_1a_2b_3b;
	reg ref_clk_i, sys_rst_i, wr_i, rd_i, cts_n_i;
	reg dsr_n_i, ri_n_i, cd_n_i;
	wire baud, dtr_n, rts_n, user2_n, int_oe;
	reg [2:0] addr_i;
	reg [7:0] wr_data_i, junk;
	wire [7:0] rd_data_o;
	wire rxd, txd_o, int_o;
	integer err_count, total_checks;
	async_serial_channel DUT (.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .rxd_i(rxd),
		.txd_o(txd_o), .baud_out_o(baud), .cts_n_i(cts_n_i),
		.dsr_n_i(dsr_n_i), .ri_n_i(ri_n_i), .cd_n_i(cd_n_i),
		.dtr_n_o(dtr_n), .rts_n_o(rts_n),
		.user_output_two_n_o(user2_n), .int_o(int_o),
		.int_oe_o(int_oe));
	remote_station peer (.ref_clk_i(ref_clk_i), .txd_i(txd_o),
		.rxd_o(rxd));
	////////////////////////////////////////////////////////////
	task wr(input [2:0] a, input [7:0] d);
		begin
			@(negedge ref_clk_i);
			addr_i = a;
			wr_data_i = d;
			wr_i = 1'b1;
			@(negedge ref_clk_i);
			wr_i = 1'b0;
		end
	endtask
	task rd(input [2:0] a, output [7:0] d);
		begin
			@(negedge ref_clk_i);
			addr_i = a;
			rd_i = 1'b1;
			@(negedge ref_clk_i);
			rd_i = 1'b0;
			d = rd_data_o;
		end
	endtask
	task chk(input [11:0] got, input [11:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("BAD %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task rchk(input [2:0] a, input [7:0] e);
		begin
			rd(a, junk);
			chk(junk, e);
		end
	endtask
	task t_regs;
		integer t;
		begin
			rchk(3'h2, 8'h01);
			rchk(3'h5, 8'h60);
			wr(3'h3, 8'h80);
			wr(3'h0, 8'h03);
			wr(3'h1, 8'ha5);
			rchk(3'h0, 8'h03);
			rchk(3'h1, 8'ha5);
			wr(3'h1, 8'h00);
			@(posedge baud);
			t = $time;
			@(posedge baud);
			chk(($time - t) / 10, 3);
			wr(3'h0, 8'h01);
			wr(3'h3, 8'h03);
			wr(3'h1, 8'hf2);
			rchk(3'h1, 8'h02);
			chk(int_o, 1'b1);
			rchk(3'h2, 8'h02);
			rchk(3'h2, 8'h01);
			// modem control pins are inverted copies of their bits; int_oe follows bit 3 uninverted
			wr(3'h4, 8'h0b);
			rchk(3'h4, 8'h0b);
			chk({dtr_n, rts_n, user2_n, int_oe}, 4'b0001);
			wr(3'h4, 8'h00);
			repeat (2) @(negedge ref_clk_i);
			chk({dtr_n, rts_n, user2_n, int_oe}, 4'b1110);
			wr(3'h7, 8'h5a);
			rchk(3'h7, 8'h5a);
			wr(3'h1, 8'h00);
			$display("test regs done");
		end
	endtask
	// every word length, stop length and parity mode, two chars each
	task t_tx;
		integer k, i, nb, par, lo, gap;
		reg [7:0] f;
		reg [11:0] bits, exp;
		begin
			for (k = 0; k < 7; k = k + 1) begin
				f = FMTS[8 * k +: 8];
				wr(3'h3, f);
				nb = 5 + f[1:0];
				par = f[3];
				exp = 12'h09d & ((12'h001 << nb) - 1);
				if (par)
					exp[nb] = f[5] ? !f[4] : (^exp ^ !f[4]);
				exp[nb + par] = 1'b1;
				lo = 16 * (1 + nb + par) + (!f[2] ? 16 : nb == 5 ? 24 : 32);
				fork
					peer.grab_frame(nb + par, bits, gap);
					begin
						wr(3'h0, 8'h9d);
						wr(3'h0, 8'h9d);
						rchk(3'h5, 8'h00);
					end
				join
				chk(bits, exp);
				chk(gap >= lo - 1 && gap <= lo + 1, 1'b1);
				junk = 8'h00;
				for (i = 0; i < 150 && !junk[6]; i = i + 1)
					rd(3'h5, junk);
				chk(junk, 8'h60);
			end
			wr(3'h3, 8'h43);
			repeat (3) @(negedge ref_clk_i);
			chk(txd_o, 1'b0);
			wr(3'h3, 8'h03);
			repeat (3) @(negedge ref_clk_i);
			chk(txd_o, 1'b1);
			$display("test tx done");
		end
	endtask
	// glitch, clean char, then overrun with a bad stop
	task t_rx;
		begin
			wr(3'h1, 8'h05);
			peer.spike;
			rchk(3'h5, 8'h60);
			peer.send(8'ha5, 1'b1);
			rchk(3'h2, 8'h04);
			chk(int_o, 1'b1);
			rchk(3'h0, 8'ha5);
			rchk(3'h2, 8'h01);
			peer.send(8'h3c, 1'b1);
			peer.send(8'hc3, 1'b0);
			rchk(3'h2, 8'h06);
			rchk(3'h5, 8'h6b);
			rchk(3'h2, 8'h04);
			rd(3'h0, junk);
			rchk(3'h2, 8'h01);
			wr(3'h1, 8'h08);
			{cts_n_i, dsr_n_i, ri_n_i, cd_n_i} = 4'h0;
			repeat (5) @(negedge ref_clk_i);
			rchk(3'h2, 8'h00);
			rd(3'h6, junk);
			chk(junk, 8'hff);
			rd(3'h6, junk);
			chk(junk, 8'hf0);
			$display("test rx done");
		end
	endtask
	// receive parity, forced parity, break and short words
	task t_rxfmt;
		begin
			wr(3'h3, 8'h1b);
			peer.send(8'h3c, 1'b1); // stop slot lands in parity cell
			rchk(3'h5, 8'h65);
			rchk(3'h0, 8'h3c);
			wr(3'h3, 8'h3b);
			peer.send(8'h3c, 1'b0);
			rchk(3'h5, 8'h61);
			rchk(3'h0, 8'h3c);
			wr(3'h3, 8'h03);
			peer.send(8'h00, 1'b0);
			rchk(3'h5, 8'h79);
			rchk(3'h0, 8'h00);
			wr(3'h3, 8'h00);
			peer.send(8'hfc, 1'b1); // upper ones keep the line at mark
			rchk(3'h5, 8'h61);
			rchk(3'h0, 8'h1c);
			$display("test rx format done");
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d errors %0d", total_checks, err_count);
			if (err_count == 0 && total_checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		{wr_i, rd_i, addr_i, wr_data_i} = 0;
		{sys_rst_i, cts_n_i, dsr_n_i, ri_n_i, cd_n_i} = 5'h1f;
		err_count = 0;
		total_checks = 0;
		repeat (10) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		t_regs;
		t_tx;
		t_rx;
		t_rxfmt;
		end_of_test;
	end
	// hang guard, several times the expected run
	initial begin
		#300000;
		err_count = err_count + 1;
		$display("BAD %0t watchdog", $time);
		end_of_test;
	end
endmodule // async_serial_channel_tb
